//--- hw/irq_ctrl.sv
// Four-level prioritising interrupt controller with Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module irq_ctrl
    import irq_ctrl_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_b,
    // Avalon-MM slave
    input wire logic [7:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    // Request flags from peripherals
    input wire logic extZeroRequestFlag,
    input wire logic extOneRequestFlag,
    input wire logic timer0OverflowFlag,
    input wire logic timer1OverflowFlag,
    input wire logic timer2OverflowFlag,
    input wire logic timer2ExternalFlag,
    input wire logic uartReceiveDone,
    input wire logic uartTransmitDone,
    input wire logic counterArrayOverflowFlag,
    input wire logic [4:0] counterModuleMatchFlag,
    input wire logic keypadRequest,
    input wire logic syncSerialRequest,
    // Core handshake
    input wire logic vectorAck,
    input wire logic returnFromIrq,
    output logic irqRequest,
    output logic [15:0] irqVector,
    output logic [1:0] irqLevel,
    output logic irqEvent
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [7:0] enMain;
        logic [6:0] plMain;
        logic [6:0] phMain;
        logic [7:0] enSecond;
        logic [7:0] plSecond;
        logic [7:0] phSecond;
        logic [3:0] inService;
        logic [2:0] evtStatus;
        logic [2:0] evtMask;
        logic [31:0] readData;
        logic waitReq;
        logic req;
        logic [15:0] vector;
        logic [1:0] level;
        logic irqOut;
    } state_type;

    state_type stateReg;
    state_type stateNext;

    logic [NUM_SRC-1:0] rawReq;
    logic [NUM_SRC-1:0] enabled;
    logic [1:0] srcLevel [NUM_SRC];
    logic winFound;
    logic [3:0] winIdx;
    logic [1:0] winLevel;
    logic [2:0] curTop;
    logic [3:0] innerMask;
    logic [7:0] wByte;
    logic [7:0] rByte;
    logic mapped;

    // ****************************************
    // Request gathering
    // ****************************************
    // nine sources
    assign rawReq[SRC_PIN0] = extZeroRequestFlag;
    assign rawReq[SRC_TIMER0] = timer0OverflowFlag;
    assign rawReq[SRC_PIN1] = extOneRequestFlag;
    assign rawReq[SRC_TIMER1] = timer1OverflowFlag;
    assign rawReq[SRC_COUNTER] = counterArrayOverflowFlag | (|counterModuleMatchFlag);
    assign rawReq[SRC_SERIAL] = uartReceiveDone | uartTransmitDone;
    assign rawReq[SRC_TIMER2] = timer2OverflowFlag | timer2ExternalFlag;
    assign rawReq[SRC_KEYPAD] = keypadRequest;
    assign rawReq[SRC_SYNC] = syncSerialRequest;

    // Per-source enable and level
    always_comb begin
        enabled[SRC_PIN0] = stateReg.enMain[0];
        enabled[SRC_TIMER0] = stateReg.enMain[1];
        enabled[SRC_PIN1] = stateReg.enMain[2];
        enabled[SRC_TIMER1] = stateReg.enMain[3];
        enabled[SRC_SERIAL] = stateReg.enMain[4];
        enabled[SRC_TIMER2] = stateReg.enMain[5];
        enabled[SRC_COUNTER] = stateReg.enMain[6];
        enabled[SRC_KEYPAD] = stateReg.enSecond[KEYPAD_BIT];
        enabled[SRC_SYNC] = stateReg.enSecond[SYNC_SERIAL_BIT];
        enabled = enabled & rawReq & {NUM_SRC{stateReg.enMain[GLOBAL_ENABLE_BIT]}};
        srcLevel[SRC_PIN0] = {stateReg.phMain[0], stateReg.plMain[0]};
        srcLevel[SRC_TIMER0] = {stateReg.phMain[1], stateReg.plMain[1]};
        srcLevel[SRC_PIN1] = {stateReg.phMain[2], stateReg.plMain[2]};
        srcLevel[SRC_TIMER1] = {stateReg.phMain[3], stateReg.plMain[3]};
        srcLevel[SRC_SERIAL] = {stateReg.phMain[4], stateReg.plMain[4]};
        srcLevel[SRC_TIMER2] = {stateReg.phMain[5], stateReg.plMain[5]};
        srcLevel[SRC_COUNTER] = {stateReg.phMain[6], stateReg.plMain[6]};
        srcLevel[SRC_KEYPAD] = {stateReg.phSecond[KEYPAD_BIT], stateReg.plSecond[KEYPAD_BIT]};
        srcLevel[SRC_SYNC] = {stateReg.phSecond[SYNC_SERIAL_BIT], stateReg.plSecond[SYNC_SERIAL_BIT]};
    end

    // ****************************************
    // Arbitration
    // ****************************************
    // Highest level, then lowest polling slot
    always_comb begin
        winFound = 1'b0;
        winIdx = 4'h0;
        winLevel = 2'h0;
        for (int i = 0; i < NUM_SRC; i++) begin
            if (enabled[i] && (!winFound || srcLevel[i] > winLevel)) begin
                winFound = 1'b1;
                winIdx = 4'(i);
                winLevel = srcLevel[i];
            end
        end
    end

    // Current top level in service, 4 means idle
    always_comb begin
        curTop = 3'h4;
        innerMask = 4'h0;
        for (int l = 0; l < 4; l++) begin
            if (stateReg.inService[l]) begin
                curTop = 3'(l);
            end
        end
        if (curTop != 3'h4) begin
            innerMask[curTop[1:0]] = 1'b1;
        end
    end

    // Vector lookup
    function automatic logic [15:0] vecOf(input logic [3:0] idx);
        case (idx)
            4'h0: vecOf = VEC_PIN0;
            4'h1: vecOf = VEC_TIMER0;
            4'h2: vecOf = VEC_PIN1;
            4'h3: vecOf = VEC_TIMER1;
            4'h4: vecOf = VEC_COUNTER;
            4'h5: vecOf = VEC_SERIAL;
            4'h6: vecOf = VEC_TIMER2;
            4'h7: vecOf = VEC_KEYPAD;
            4'h8: vecOf = VEC_SYNC;
            default: vecOf = VEC_RESET;
        endcase
    endfunction : vecOf

    // ****************************************
    // Register bus decode
    // ****************************************
    assign wByte = avsByteEnable[0] ? avsWriteData[7:0] : 8'h00;
    always_comb begin
        mapped = 1'b1;
        if (avsAddress == ENABLE_MAIN_OFS) begin
            rByte = stateReg.enMain;
        end else if (avsAddress == PRIO_LOW_MAIN_OFS) begin
            rByte = {1'b0, stateReg.plMain};
        end else if (avsAddress == PRIO_HIGH_MAIN_OFS) begin
            rByte = {1'b0, stateReg.phMain};
        end else if (avsAddress == ENABLE_SECOND_OFS) begin
            rByte = stateReg.enSecond;
        end else if (avsAddress == PRIO_LOW_SECOND_OFS) begin
            rByte = stateReg.plSecond;
        end else if (avsAddress == PRIO_HIGH_SECOND_OFS) begin
            rByte = stateReg.phSecond;
        end else if (avsAddress == EVENT_STATUS_OFS) begin
            rByte = {5'h00, stateReg.evtStatus};
        end else if (avsAddress == EVENT_MASK_OFS) begin
            rByte = {5'h00, stateReg.evtMask};
        end else if (avsAddress == SERVICE_STATUS_OFS) begin
            rByte = {4'h0, stateReg.inService};
        end else begin
            rByte = UNMAPPED_READ;
            mapped = 1'b0;
        end
    end

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic access;
        logic wrOk;
        logic [2:0] setEvt;
        access = 1'b0;
        wrOk = 1'b0;
        setEvt = 3'h0;
        stateNext = stateReg;
        // One wait cycle per access, answer on second cycle
        access = (avsRead | avsWrite) & stateReg.waitReq;
        stateNext.waitReq = ~((avsRead | avsWrite) & stateReg.waitReq);
        wrOk = avsWrite & stateReg.waitReq & avsByteEnable[0];
        if (avsRead && stateReg.waitReq) begin
            stateNext.readData = {24'h000000, rByte};
        end
        if (wrOk && mapped) begin
            if (avsAddress == ENABLE_MAIN_OFS) begin
                stateNext.enMain = wByte;
            end else if (avsAddress == PRIO_LOW_MAIN_OFS) begin
                stateNext.plMain = wByte[MAIN_FIELD_WIDTH-1:0];
            end else if (avsAddress == PRIO_HIGH_MAIN_OFS) begin
                stateNext.phMain = wByte[MAIN_FIELD_WIDTH-1:0];
            end else if (avsAddress == ENABLE_SECOND_OFS) begin
                stateNext.enSecond = wByte & SECOND_MASK;
            end else if (avsAddress == PRIO_LOW_SECOND_OFS) begin
                stateNext.plSecond = wByte & SECOND_MASK;
            end else if (avsAddress == PRIO_HIGH_SECOND_OFS) begin
                stateNext.phSecond = wByte & SECOND_MASK;
            end else if (avsAddress == EVENT_MASK_OFS) begin
                stateNext.evtMask = wByte[2:0];
            end
        end
        if (wrOk && (avsAddress == BIT_SET_OFS || avsAddress == BIT_CLEAR_OFS)) begin
            if (!wByte[SEL_REG_BIT]) begin
                stateNext.enMain[wByte[2:0]] = (avsAddress == BIT_SET_OFS);
            end else if (wByte[2:0] != 3'h7) begin
                stateNext.plMain[wByte[2:0]] = (avsAddress == BIT_SET_OFS);
            end
        end
        if (returnFromIrq) begin
            stateNext.inService = stateReg.inService & ~innerMask;
            setEvt[EVT_RETURN] = 1'b1;
            setEvt[EVT_STRAY_RETURN] = (curTop == 3'h4);
        end
        // Offer the winner when it may preempt
        // strictly higher only
        stateNext.req = winFound && (curTop == 3'h4 || {1'b0, winLevel} > curTop);
        stateNext.vector = vecOf(winIdx);
        stateNext.level = winLevel;
        if (vectorAck && stateReg.req) begin
            stateNext.inService[stateReg.level] = 1'b1;
            stateNext.req = 1'b0;
            setEvt[EVT_TAKEN] = 1'b1;
        end
        // Sticky events: set wins over write-one-clear
        if (wrOk && avsAddress == EVENT_STATUS_OFS) begin
            stateNext.evtStatus = stateReg.evtStatus & ~wByte[2:0];
        end
        stateNext.evtStatus = stateNext.evtStatus | setEvt;
        stateNext.irqOut = |(stateNext.evtStatus & stateNext.evtMask);
        if (access) begin
            stateNext.waitReq = 1'b0;
        end
    end

    // State register
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            stateReg <= '{enMain: ENABLE_MAIN_RESET, plMain: PRIO_MAIN_RESET[6:0],
                phMain: PRIO_MAIN_RESET[6:0], enSecond: SECOND_RESET, plSecond: SECOND_RESET,
                phSecond: SECOND_RESET, waitReq: 1'b1, default: '0};
        end else begin
            stateReg <= stateNext;
        end
    end

    // Outputs straight from flops
    assign avsReadData = stateReg.readData;
    assign avsWaitRequest = stateReg.waitReq;
    assign irqRequest = stateReg.req;
    assign irqVector = stateReg.vector;
    assign irqLevel = stateReg.level;
    assign irqEvent = stateReg.irqOut;

    // ****************************************
    // Checks
    // ****************************************
    AST_GLOBAL_OFF: assert property (@(posedge core_clk) disable iff (!rst_b)
        !stateReg.enMain[GLOBAL_ENABLE_BIT] |=> !irqRequest) else $error("request with global enable off");
    AST_OWN_ENABLE: assert property (@(posedge core_clk) disable iff (!rst_b)
        ((rawReq & {stateReg.enSecond[SYNC_SERIAL_BIT], stateReg.enSecond[KEYPAD_BIT], stateReg.enMain[5:4],
        stateReg.enMain[6], stateReg.enMain[3:0]}) == '0) |=> !irqRequest) else $error("request from disabled source");
    AST_TOP_BLOCKS: assert property (@(posedge core_clk) disable iff (!rst_b)
        stateReg.inService[3] |=> !irqRequest) else $error("request during level 3 service");
    AST_PREEMPT: assert property (@(posedge core_clk) disable iff (!rst_b)
        (irqRequest && $past(curTop) != 3'h4) |-> ({1'b0, irqLevel} > $past(curTop)))
        else $error("preemption by non-higher level");
    AST_PIN0_VEC: assert property (@(posedge core_clk) disable iff (!rst_b)
        (enabled[SRC_PIN0] && srcLevel[SRC_PIN0] == 2'h3) |=> irqVector == 16'h0003)
        else $error("pin 0 vector wrong");
    AST_SYNC_VEC: assert property (@(posedge core_clk) disable iff (!rst_b)
        (enabled == 9'h100) |=> irqVector == 16'h004b) else $error("sync serial vector wrong");
    AST_LEVEL_WIN: assert property (@(posedge core_clk) disable iff (!rst_b)
        (enabled[SRC_SYNC] && srcLevel[SRC_SYNC] == 2'h3) |=> irqLevel == 2'h3)
        else $error("higher level lost");
    AST_RETI: assert property (@(posedge core_clk) disable iff (!rst_b)
        (returnFromIrq && !vectorAck && curTop != 3'h4) |=>
        stateReg.inService == ($past(stateReg.inService) & ~$past(innerMask)))
        else $error("return did not release level");
    AST_BUS_ANSWER: assert property (@(posedge core_clk) disable iff (!rst_b)
        (avsRead && avsWaitRequest) |=> !avsWaitRequest) else $error("bus answer late");
endmodule : irq_ctrl
`default_nettype wire

//--- hw/irq_ctrl_pkg.sv
// Package of constants and register map for the interrupt controller
package irq_ctrl_pkg;
    // ****************************************
    // Register map (byte addresses = printed offsets)
    // ****************************************
    localparam logic [7:0] ENABLE_MAIN_OFS = 8'ha8;
    localparam logic [7:0] PRIO_LOW_MAIN_OFS = 8'hb8;
    localparam logic [7:0] PRIO_HIGH_MAIN_OFS = 8'hb7;
    localparam logic [7:0] ENABLE_SECOND_OFS = 8'hb1;
    localparam logic [7:0] PRIO_LOW_SECOND_OFS = 8'hb2;
    localparam logic [7:0] PRIO_HIGH_SECOND_OFS = 8'hb3;
    localparam logic [7:0] BIT_SET_OFS = 8'hc0;
    localparam logic [7:0] BIT_CLEAR_OFS = 8'hc1;
    localparam logic [7:0] EVENT_STATUS_OFS = 8'hc2;
    localparam logic [7:0] EVENT_MASK_OFS = 8'hc3;
    localparam logic [7:0] SERVICE_STATUS_OFS = 8'hc4;
    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int GLOBAL_ENABLE_BIT = 7;
    localparam int MAIN_FIELD_WIDTH = 7;
    localparam int SYNC_SERIAL_BIT = 2;
    localparam int KEYPAD_BIT = 0;
    localparam logic [7:0] ENABLE_MAIN_RESET = 8'h00;
    localparam logic [7:0] PRIO_MAIN_RESET = 8'h00;
    localparam logic [7:0] SECOND_RESET = 8'h00;
    localparam logic [7:0] SECOND_MASK = 8'h05;
    localparam logic [7:0] MAIN_PRIO_MASK = 8'h7f;
    // Bit-select command: bit 3 picks register (0 enable, 1 low prio), bits 2:0 bit index
    localparam int SEL_REG_BIT = 3;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;
    // ****************************************
    // Sources, in polling order
    // ****************************************
    localparam int NUM_SRC = 9;
    localparam int SRC_PIN0 = 0;
    localparam int SRC_TIMER0 = 1;
    localparam int SRC_PIN1 = 2;
    localparam int SRC_TIMER1 = 3;
    localparam int SRC_COUNTER = 4;
    localparam int SRC_SERIAL = 5;
    localparam int SRC_TIMER2 = 6;
    localparam int SRC_KEYPAD = 7;
    localparam int SRC_SYNC = 8;
    // Vectors per polling slot
    localparam logic [15:0] VEC_RESET = 16'h0000;
    localparam logic [15:0] VEC_PIN0 = 16'h0003;
    localparam logic [15:0] VEC_TIMER0 = 16'h000b;
    localparam logic [15:0] VEC_PIN1 = 16'h0013;
    localparam logic [15:0] VEC_TIMER1 = 16'h001b;
    localparam logic [15:0] VEC_SERIAL = 16'h0023;
    localparam logic [15:0] VEC_TIMER2 = 16'h002b;
    localparam logic [15:0] VEC_COUNTER = 16'h0033;
    localparam logic [15:0] VEC_KEYPAD = 16'h003b;
    localparam logic [15:0] VEC_SPARE = 16'h0043;
    localparam logic [15:0] VEC_SYNC = 16'h004b;
    // Event status bits
    localparam int EVT_TAKEN = 0;
    localparam int EVT_RETURN = 1;
    localparam int EVT_STRAY_RETURN = 2;
endpackage : irq_ctrl_pkg

//--- tb/core_model.sv
// Core model that takes offered vectors and ends services
`timescale 1ns/1ps
`default_nettype none
module core_model (
    input wire logic core_clk,
    input wire logic irqRequest,
    input wire logic [15:0] irqVector,
    input wire logic [1:0] irqLevel,
    input wire logic [1:0] ackDelay,
    output logic vectorAck,
    output logic returnFromIrq
);
    logic [15:0] lastVector;
    logic [1:0] lastLevel;
    int ackCount;
    int waitCnt;
    // Accept an offer after a chosen stall, one cycle pulse
    initial begin
        {vectorAck, returnFromIrq} = 2'b00;
        ackCount = 0;
        waitCnt = 0;
        forever begin
            @(negedge core_clk);
            if (irqRequest !== 1'b1) begin
                waitCnt = 0;
            end else if (waitCnt < int'(ackDelay)) begin
                waitCnt++;
            end else begin
                @(posedge core_clk);
                vectorAck <= 1'b1;
                @(negedge core_clk);
                lastVector = irqVector; // Value seen at the taking edge
                lastLevel = irqLevel;
                @(posedge core_clk);
                vectorAck <= 1'b0;
                ackCount++;
                waitCnt = 0;
            end
        end
    end
    // End of the innermost service
    task automatic do_return();
        @(posedge core_clk);
        returnFromIrq <= 1'b1;
        @(posedge core_clk);
        returnFromIrq <= 1'b0;
    endtask : do_return
endmodule : core_model
`default_nettype wire

//--- tb/tb.sv
// Self-checking bench for the four-level interrupt controller
`timescale 1ns/1ps
`default_nettype none
module tb
    import irq_ctrl_pkg::*;
;
    logic core_clk, rst_b, avsRead, avsWrite, avsWaitRequest, irqRequest, irqEvent, vectorAck, returnFromIrq, globalEn;
    logic [7:0] avsAddress;
    logic [31:0] avsWriteData, avsReadData, rd;
    logic [3:0] avsByteEnable;
    logic [8:0] flags, srcEn;
    logic [2:0] sub;
    logic [15:0] irqVector;
    logic [1:0] irqLevel, ackDelay, lv;
    logic [1:0] srcLvl [9];
    int n_errors, comparisons, a, b, w;
    integer seed;

    irq_ctrl DUT (.core_clk(core_clk), .rst_b(rst_b), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .extZeroRequestFlag(flags[0]),
        .extOneRequestFlag(flags[2]), .timer0OverflowFlag(flags[1]), .timer1OverflowFlag(flags[3]),
        .timer2OverflowFlag(flags[6] & ~sub[0]), .timer2ExternalFlag(flags[6] & sub[0]),
        .uartReceiveDone(flags[5] & ~sub[0]), .uartTransmitDone(flags[5] & sub[0]),
        .counterArrayOverflowFlag(flags[4] && sub == 3'h5),
        .counterModuleMatchFlag((flags[4] && sub < 3'h5) ? 5'h01 << sub : 5'h00),
        .keypadRequest(flags[7]), .syncSerialRequest(flags[8]), .vectorAck(vectorAck),
        .returnFromIrq(returnFromIrq), .irqRequest(irqRequest), .irqVector(irqVector), .irqLevel(irqLevel),
        .irqEvent(irqEvent));
    core_model core (.core_clk(core_clk), .irqRequest(irqRequest), .irqVector(irqVector), .irqLevel(irqLevel),
        .ackDelay(ackDelay), .vectorAck(vectorAck), .returnFromIrq(returnFromIrq));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic int rnd(int n);
        return int'($unsigned($random(seed)) % n);
    endfunction : rnd
    // Register bit of each source, polling order
    function automatic int src_bit(int s);
        int t [9] = '{0, 1, 2, 3, 6, 4, 5, 0, 2};
        return t[s];
    endfunction : src_bit
    function automatic logic [15:0] exp_vec(int s);
        logic [15:0] v [9] = '{16'h0003, 16'h000b, 16'h0013, 16'h001b, 16'h0033, 16'h0023, 16'h002b, 16'h003b,
            16'h004b};
        return v[s];
    endfunction : exp_vec
    task automatic test_done();
        if (n_errors == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check
    // One bus transfer, held until waitrequest is seen low
    task automatic bus(input logic [7:0] adr, input logic wrt, input logic [7:0] d);
        int i;
        @(posedge core_clk);
        avsAddress <= adr;
        avsWriteData <= {24'h000000, d};
        avsWrite <= wrt;
        avsRead <= !wrt;
        i = 0;
        // Sample waitrequest at each rising edge, take the answer at the first one seen low
        do begin
            @(posedge core_clk);
            i++;
        end while (avsWaitRequest !== 1'b0 && i < 50);
        if (avsWaitRequest !== 1'b0) begin
            check(32'h0, 32'h1);
            test_done();
        end
        rd = avsReadData;
        {avsWrite, avsRead} <= 2'b00;
    endtask : bus
    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        bus(adr, 1'b1, d);
    endtask : wr
    task automatic rd_chk(input logic [7:0] adr, input logic [7:0] exp);
        bus(adr, 1'b0, 8'h00);
        check(rd, {24'h000000, exp});
    endtask : rd_chk
    // Write all six control registers from the bench shadow
    task automatic cfg(input int x, input logic [1:0] lx, input int y, input logic [1:0] ly);
        logic [7:0] r [6];
        r = '{default: 8'h00};
        srcEn = 9'h000;
        srcEn[x] = 1'b1;
        srcEn[y] = 1'b1;
        srcLvl[x] = lx;
        srcLvl[y] = ly;
        for (int s = 0; s < 9; s++) begin
            int k = (s < 7) ? 0 : 1;
            r[k][src_bit(s)] = srcEn[s];
            r[k + 2][src_bit(s)] = srcLvl[s][0];
            r[k + 4][src_bit(s)] = srcLvl[s][1];
        end
        r[0][7] = globalEn;
        wr(8'ha8, r[0]);
        wr(8'hb1, r[1]);
        wr(8'hb8, r[2]);
        wr(8'hb2, r[3]);
        wr(8'hb7, r[4]);
        wr(8'hb3, r[5]);
    endtask : cfg
    task automatic raise(input logic [8:0] m);
        @(posedge core_clk);
        sub <= 3'(rnd(6));
        ackDelay <= 2'(rnd(4));
        flags <= flags | m;
    endtask : raise
    task automatic drop(input logic [8:0] m);
        @(posedge core_clk);
        flags <= flags & ~m;
    endtask : drop
    // Wait for the core to take a vector, then compare it
    task automatic expect_service(input int s, input logic [1:0] lvl);
        int n0 = core.ackCount;
        int i;
        for (i = 0; i < 40 && core.ackCount == n0; i++) begin
            @(negedge core_clk);
        end
        check(32'(i == 40), 32'h0);
        if (i == 40) begin
            test_done();
        end
        check(core.lastVector, exp_vec(s));
        check(core.lastLevel, lvl);
    endtask : expect_service
    task automatic expect_none();
        int n0 = core.ackCount;
        repeat (12) @(negedge core_clk);
        check(core.ackCount, n0);
        check(irqRequest, 1'b0);
    endtask : expect_none

    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        seed = 32'h15a8;
        {rst_b, avsRead, avsWrite, globalEn, n_errors, comparisons} = '0;
        {avsAddress, avsWriteData, flags, sub, ackDelay, srcEn} = '0;
        srcLvl = '{default: 2'b00};
        avsByteEnable = 4'hf;
        repeat (8) @(posedge core_clk);
        rst_b <= 1'b1;
        // Reset values and one unmapped place
        for (int i = 0; i < 8; i++) begin
            a = 8'({8'ha8, 8'hb8, 8'hb7, 8'hb1, 8'hb2, 8'hb3, 8'h10, 8'hc4} >> (56 - 8 * i));
            rd_chk(8'(a), 8'h00);
        end
        wr(8'h10, 8'hff);
        rd_chk(8'h10, 8'h00);
        // Reserved bits read zero
        for (int i = 0; i < 4; i++) begin
            a = 8'({8'hb1, 8'hb8, 8'hb3, 8'hb7} >> (24 - 8 * i));
            wr(8'(a), 8'hff);
            rd_chk(8'(a), (i[0]) ? 8'h7f : 8'h05);
            wr(8'(a), 8'h00);
        end
        avsByteEnable <= 4'he;
        wr(8'ha8, 8'hff);
        avsByteEnable <= 4'hf;
        rd_chk(8'ha8, 8'h00);
        // Single-bit set then clear on both bit-addressable registers
        for (int r = 0; r < 2; r++) begin
            for (int i = 0; i < 8; i++) begin
                wr(8'hc0, 8'(r * 8 + i));
                rd_chk(r ? 8'hb8 : 8'ha8, (8'hff >> (7 - i)) & (r ? 8'h7f : 8'hff));
            end
            for (int i = 0; i < 8; i++) begin
                wr(8'hc1, 8'(r * 8 + i));
                rd_chk(r ? 8'hb8 : 8'ha8, (8'hfe << i) & (r ? 8'h7f : 8'hff));
            end
        end
        // Every source alone, any sub-flag of merged requests
        globalEn = 1'b1;
        for (int s = 0; s < 9; s++) begin
            lv = 2'(rnd(4));
            cfg(s, lv, s, lv);
            raise(9'(1 << s));
            expect_service(s, lv);
            drop(9'h1ff);
            core.do_return();
        end
        // Global and own enables
        a = rnd(9);
        globalEn = 1'b0;
        cfg(a, 2'b11, a, 2'b11);
        raise(9'(1 << a));
        expect_none();
        // Another source enabled, the requesting one not, then global on by bit set
        cfg((a + 1) % 9, 2'b11, (a + 1) % 9, 2'b11);
        wr(8'hc0, 8'h07);
        expect_none();
        // One write enables the waiting source
        globalEn = 1'b1;
        if (a < 7) begin
            wr(8'hc0, 8'(src_bit(a)));
        end else begin
            wr(8'hb1, 8'(1 << src_bit(a)));
        end
        expect_service(a, 2'b11);
        drop(9'h1ff);
        core.do_return();
        // Random pairs raised together
        repeat (24) begin
            a = rnd(9);
            b = (a + 1 + rnd(8)) % 9;
            cfg(a, 2'(rnd(4)), b, 2'(rnd(4)));
            w = (srcLvl[a] != srcLvl[b]) ? ((srcLvl[a] > srcLvl[b]) ? a : b) : ((a < b) ? a : b);
            raise(9'((1 << a) | (1 << b)));
            expect_service(w, srcLvl[w]);
            drop(9'(1 << w));
            core.do_return();
            expect_service(a + b - w, srcLvl[a + b - w]);
            drop(9'h1ff);
            core.do_return();
        end
        // Nesting: last-polled source in service, first-polled one arrives
        for (int c = 0; c < 4; c++) begin
            for (int n = 0; n < 4; n++) begin
                cfg(8, 2'(c), 0, 2'(n));
                raise(9'h100);
                expect_service(8, 2'(c));
                drop(9'h100);
                raise(9'h001);
                if (n > c) begin
                    expect_service(0, 2'(n));
                    drop(9'h001);
                    core.do_return();
                end else begin
                    expect_none();
                    core.do_return();
                    expect_service(0, 2'(n));
                    drop(9'h001);
                end
                core.do_return();
            end
        end
        // Event status, mask and level interrupt
        wr(8'hc3, 8'h00);
        wr(8'hc2, 8'h07);
        core.do_return();
        rd_chk(8'hc2, 8'h06);
        check(irqEvent, 1'b0);
        wr(8'hc3, 8'h04);
        @(negedge core_clk);
        check(irqEvent, 1'b1);
        wr(8'hc2, 8'h04);
        @(negedge core_clk);
        check(irqEvent, 1'b0);
        cfg(0, 2'b01, 0, 2'b01);
        raise(9'h001);
        expect_service(0, 2'b01);
        drop(9'h001);
        core.do_return();
        rd_chk(8'hc2, 8'h03);
        wr(8'hc3, 8'h03);
        wr(8'hc2, 8'h01);
        @(negedge core_clk);
        check(irqEvent, 1'b1);
        wr(8'hc2, 8'h02);
        @(negedge core_clk);
        check(irqEvent, 1'b0);
        test_done();
    end
endmodule : tb
`default_nettype wire
